// ==== usmr_pkg.sv ====
// Package of constants for the modem, status and pin block
package usmr_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] ADDR_TXBUF   = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_LSR     = 8'h08;
  localparam logic [7:0] ADDR_MCR     = 8'h0C;
  localparam logic [7:0] ADDR_BAUD    = 8'h10;
  localparam logic [7:0] ADDR_MSR     = 8'h14;
  // Modem control fields
  localparam int MCR_DTR   = 0;
  localparam int MCR_RTS   = 1;
  localparam int MCR_GIE   = 2;
  localparam int MCR_MIE   = 3;
  localparam int MCR_LOOP  = 4;
  localparam int MCR_RXEN  = 5;
  localparam logic [7:0] MCR_RST_VAL = 8'h00;
  // Baud select fields
  localparam int BRS_CO_SEL = 7;
  localparam logic [7:0] BRS_RST_VAL = 8'h00;
  localparam logic [7:0] BRS_MASK    = 8'h7F;
  // Line status fields
  localparam int LSR_DR  = 0;
  localparam int LSR_TBE = 6;
  localparam int LSR_TC  = 7;
  localparam logic [7:0] LSR_RST_VAL = 8'hC0;
  // Modem status fields
  localparam int MSR_CTS  = 0;
  localparam int MSR_DSR  = 1;
  localparam int MSR_DCTS = 2;
  localparam int MSR_DDSR = 3;
  // Control register: run enable for tx, rx and baud, resume after reset
  localparam int CTRL_RUN = 0;
  // Oversampling ratio of bit clock
  localparam int OVERSAMPLE = 16;
  localparam logic [15:0] DIV_RST_VAL = 16'h0001;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} usmr_tx_t;
endpackage

// ==== usmr_sync.sv ====
// Two-flop synchroniser for one level
`timescale 1ns/1ns
module usmr_sync
  import usmr_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Level
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else if (ce) begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

// ==== usmr_baud.sv ====
// Baud tick generator at 16x the bit rate
`timescale 1ns/1ns
module usmr_baud
  import usmr_pkg::*;
#(
  parameter int DIV_W = 16
)(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             run,
  // Divider and outputs
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick16,
  output logic                  clk16
);
  logic [DIV_W-1:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= '0;
      tick16 <= 1'b0;
      clk16  <= 1'b0;
    end else if (ce) begin
      // Counters stay cleared while idle
      if (!run) begin
        cnt_r  <= '0;
        tick16 <= 1'b0;
      end else if (cnt_r + 1'b1 >= divisor) begin
        cnt_r  <= '0;
        tick16 <= 1'b1;
        clk16  <= ~clk16;
      end else begin
        cnt_r  <= cnt_r + 1'b1;
        tick16 <= 1'b0;
      end
    end
  end
endmodule

// ==== usmr_top.sv ====
// UART modem, status and pin logic with APB register access
//
// Functional notes
// - Mirror clear-to-send; change may interrupt
// - Clear-to-send false: no start, line mark
// - Finish current character when clear-to-send drops
// - Loop mode ignores clear-to-send
// - Mirror data-set-ready; change may interrupt
// - Data-set-ready affects nothing else
// - Terminal-ready pin low when bit set
// - Request-to-send pin low when bit set
// - Clock out: oscillator or 16x clock
// - Reset clears clock-out select bit
// - Buffer-empty set on transfer, cleared by write
// - Reset idles device, clears modem control
// - Reset sets buffer-empty and complete bits only
// - Stay idle until software resumes operation
// - Global enable gates irq; modem enable feeds
// - Receiver ignores input in loop or reset
// - High level is mark, low is space
// - Data-ready set on receive, cleared on read
// - Strobes ignored without chip select
// - Irq low while global enable false
// - Serial out mark in all quiet conditions
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module usmr_top
  import usmr_pkg::*;
#(
  parameter int DIV_W = 16
)(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        osc_in,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Modem pins
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  output logic             dtr_n,
  output logic             rts_n,
  // Serial pins
  input  wire logic        serial_rx_line,
  output logic             serial_tx_pin,
  // Status pins
  output logic             tx_buffer_empty,
  output logic             rx_data_ready,
  output logic             irq_out,
  output logic             clock_out_pin
);
  logic [7:0]       modem_control_reg_r;
  logic [7:0]       baud_select_reg_r;
  logic [DIV_W-1:0] divisor_r;
  logic             run_r;
  logic [7:0]       tx_holding_buffer_r;
  logic             tbe_r;
  logic             tc_r;
  logic [7:0]       rx_holding_buffer_r;
  logic             dr_r;
  logic             overrun_r;
  logic             dcts_r, ddsr_r;
  logic             cts_q_r, dsr_q_r;
  logic             cts_s, dsr_s, rx_s;
  logic             tick16, clk16;
  usmr_tx_t         tx_st_r;
  logic [3:0]       tx_sub_r;
  logic [3:0]       tx_bit_r;
  logic [9:0]       tx_shift_r;
  usmr_tx_t         rx_st_r;
  logic [3:0]       rx_sub_r;
  logic [3:0]       rx_bit_r;
  logic [7:0]       rx_shift_r;
  logic             loop_line;
  logic             apb_wr, apb_rd;
  logic             gie, mie;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign gie    = modem_control_reg_r[MCR_GIE];
  assign mie    = modem_control_reg_r[MCR_MIE];

  // Synchronised modem and line inputs
  usmr_sync u_sync_cts (.pclk(pclk), .presetn(presetn), .ce(ce),
                        .din(~cts_n), .dout(cts_s));
  usmr_sync u_sync_dsr (.pclk(pclk), .presetn(presetn), .ce(ce),
                        .din(~dsr_n), .dout(dsr_s));
  usmr_sync u_sync_rx  (.pclk(pclk), .presetn(presetn), .ce(ce),
                        .din(~serial_rx_line), .dout(rx_s));

  usmr_baud #(.DIV_W(DIV_W)) u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (run_r),
    .divisor (divisor_r),
    .tick16  (tick16),
    .clk16   (clk16)
  );

  // APB always answers in the access cycle; APB select stands in for
  // chip select, so strobes without it do nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end
  end

  // Read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_TXBUF: prdata <= {24'h0, rx_holding_buffer_r};
        ADDR_CTRL:  prdata <= {31'h0, run_r};
        ADDR_LSR:   prdata <= {24'h0, tc_r, tbe_r, 4'h0, overrun_r, dr_r};
        ADDR_MCR:   prdata <= {24'h0, modem_control_reg_r};
        ADDR_BAUD:  prdata <= {{(32-DIV_W){1'b0}}, divisor_r};
        ADDR_MSR:   prdata <= {28'h0, ddsr_r, dcts_r, dsr_s, cts_s};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Modem control register; reset clears it and its pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_control_reg_r <= MCR_RST_VAL;
    end else if (ce && apb_wr && hit(paddr, ADDR_MCR)) begin
      modem_control_reg_r <= pwdata[7:0];
    end
  end

  // Baud select: bit 7 picks clock out, the low DIV_W bits (bit 7 too) run the divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_select_reg_r <= BRS_RST_VAL;
      divisor_r         <= DIV_W'(DIV_RST_VAL);
    end else if (ce && apb_wr && hit(paddr, ADDR_BAUD)) begin
      baud_select_reg_r <= pwdata[7:0];
      // A zero divisor would act as one, ticking every cycle; bit 0 is forced
      // Limitation: odd divisors only differ from even ones by one
      divisor_r         <= pwdata[DIV_W-1:0] | DIV_W'(DIV_RST_VAL);
    end
  end

  // Idle after reset until software writes the run bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
    end else if (ce && apb_wr && hit(paddr, ADDR_CTRL)) begin
      run_r <= pwdata[CTRL_RUN];
    end
  end

  // Modem change flags; set wins over clear-on-read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_q_r <= 1'b0;
      dsr_q_r <= 1'b0;
      dcts_r  <= 1'b0;
      ddsr_r  <= 1'b0;
    end else if (ce) begin
      cts_q_r <= cts_s;
      dsr_q_r <= dsr_s;
      if (cts_s != cts_q_r)
        dcts_r <= 1'b1;
      else if (apb_rd && hit(paddr, ADDR_MSR))
        dcts_r <= 1'b0;
      if (dsr_s != dsr_q_r)
        ddsr_r <= 1'b1;
      else if (apb_rd && hit(paddr, ADDR_MSR))
        ddsr_r <= 1'b0;
    end
  end

  // Transmit holding buffer and empty flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_holding_buffer_r <= 8'h00;
      tbe_r               <= LSR_RST_VAL[LSR_TBE];
    end else if (ce) begin
      if (apb_wr && hit(paddr, ADDR_TXBUF)) begin
        tx_holding_buffer_r <= pwdata[7:0];
        tbe_r               <= 1'b0;
      end else if (tx_st_r == TX_IDLE && !tbe_r && tick16
                   && (cts_s || modem_control_reg_r[MCR_LOOP])) begin
        tbe_r <= 1'b1;
      end
    end
  end

  // Transmitter: start only with clear-to-send unless looping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r    <= TX_IDLE;
      tx_sub_r   <= 4'h0;
      tx_bit_r   <= 4'h0;
      tx_shift_r <= 10'h3FF;
      tc_r       <= LSR_RST_VAL[LSR_TC];
    end else if (ce && !run_r) begin
      tx_st_r    <= TX_IDLE;
      tx_shift_r <= 10'h3FF;
    end else if (ce && tick16) begin
      case (tx_st_r)
        TX_IDLE: begin
          if (!tbe_r && (cts_s || modem_control_reg_r[MCR_LOOP])) begin
            tx_shift_r <= {1'b1, tx_holding_buffer_r, 1'b0};
            tx_st_r    <= TX_SHIFT;
            tx_sub_r   <= 4'h0;
            tx_bit_r   <= 4'h0;
            tc_r       <= 1'b0;
          end
        end
        TX_SHIFT: begin
          // Clear-to-send not checked here: the character completes
          tx_sub_r <= tx_sub_r + 4'h1;
          if (tx_sub_r == 4'(OVERSAMPLE - 1)) begin
            tx_shift_r <= {1'b1, tx_shift_r[9:1]};
            tx_bit_r   <= tx_bit_r + 4'h1;
            if (tx_bit_r == 4'd9) begin
              tx_st_r <= TX_IDLE;
              tc_r    <= 1'b1;
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // Loop mode routes the transmitter into the receiver
  assign loop_line = tx_shift_r[0];

  // Serial out marks when idle, looping or stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_tx_pin <= 1'b1;
    end else if (ce) begin
      serial_tx_pin <= (tx_st_r == TX_SHIFT)
                       && !modem_control_reg_r[MCR_LOOP]
                       ? tx_shift_r[0] : 1'b1;
    end
  end

  // Receiver; rx_s is inverted line, so high rx_s is space
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r    <= TX_IDLE;
      rx_sub_r   <= 4'h0;
      rx_bit_r   <= 4'h0;
      rx_shift_r <= 8'h00;
    end else if (ce && !run_r) begin
      rx_st_r <= TX_IDLE;
    end else if (ce && tick16) begin
      case (rx_st_r)
        TX_IDLE: begin
          // Pin ignored in loop mode or when disabled
          if (modem_control_reg_r[MCR_LOOP] ? !loop_line
              : (modem_control_reg_r[MCR_RXEN] && rx_s)) begin
            rx_st_r  <= TX_SHIFT;
            rx_sub_r <= 4'h0;
            rx_bit_r <= 4'h0;
          end
        end
        TX_SHIFT: begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r == 4'(OVERSAMPLE/2 - 1)) begin
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r >= 4'd1 && rx_bit_r <= 4'd8)
              rx_shift_r <= {modem_control_reg_r[MCR_LOOP] ? loop_line
                             : !rx_s, rx_shift_r[7:1]};
            if (rx_bit_r == 4'd9)
              rx_st_r <= TX_IDLE;
          end
        end
        default: rx_st_r <= TX_IDLE;
      endcase
    end
  end

  // Receive buffer and data-ready; new data wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_holding_buffer_r <= 8'h00;
      dr_r                <= 1'b0;
      overrun_r           <= 1'b0;
    end else if (ce) begin
      if (tick16 && rx_st_r == TX_SHIFT && rx_bit_r == 4'd9
          && rx_sub_r == 4'(OVERSAMPLE/2 - 1)) begin
        rx_holding_buffer_r <= rx_shift_r;
        dr_r                <= 1'b1;
        overrun_r           <= dr_r;
      end else if (apb_rd && hit(paddr, ADDR_TXBUF)) begin
        dr_r <= 1'b0;
      end
    end
  end

  // Registered output pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr_n           <= 1'b1;
      rts_n           <= 1'b1;
      irq_out         <= 1'b0;
      tx_buffer_empty <= 1'b1;
      rx_data_ready   <= 1'b0;
      clock_out_pin   <= 1'b0;
    end else if (ce) begin
      dtr_n           <= ~modem_control_reg_r[MCR_DTR];
      rts_n           <= ~modem_control_reg_r[MCR_RTS];
      // Buffer and receive events share the one request line
      irq_out         <= gie && ((mie && (dcts_r || ddsr_r))
                                 || dr_r || tbe_r);
      tx_buffer_empty <= tbe_r;
      rx_data_ready   <= dr_r;
      // Buffered oscillator is sampled, so it follows at pclk rate
      clock_out_pin   <= baud_select_reg_r[BRS_CO_SEL]
                         ? clk16 : osc_in;
    end
  end
endmodule

// ==== usmr_top_asserts.sv ====
// Port checker for the modem, status and pin block
`timescale 1ns/1ns
module usmr_top_chk
  import usmr_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        osc_in,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Pins
  input wire logic        cts_n,
  input wire logic        dtr_n,
  input wire logic        rts_n,
  input wire logic        serial_tx_pin,
  input wire logic        tx_buffer_empty,
  input wire logic        rx_data_ready,
  input wire logic        irq_out,
  input wire logic        clock_out_pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       wr;
  logic       gie_r;
  logic       mie_r;
  logic       co_r;
  logic [7:0] mark_cnt;
  assign wr = psel && penable && pwrite;
  // Shadow of control bits, taken at the APB write edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_r <= 1'b0;
      mie_r <= 1'b0;
      co_r  <= 1'b0;
    end else if (wr && paddr == ADDR_MCR) begin
      gie_r <= pwdata[MCR_GIE];
      mie_r <= pwdata[MCR_MIE];
    end else if (wr && paddr == ADDR_BAUD) begin
      co_r  <= pwdata[BRS_CO_SEL];
    end
  end
  // Long mark run means no character is in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mark_cnt <= 8'h00;
    else if (!serial_tx_pin)
      mark_cnt <= 8'h00;
    else if (mark_cnt != 8'hFF)
      mark_cnt <= mark_cnt + 8'h01;
  end
  dtr_pin_a: assert property (
    wr && paddr == ADDR_MCR |-> ##2 dtr_n == !$past(pwdata[MCR_DTR], 2))
    else $error("dtr pin wrong");
  rts_pin_a: assert property (
    wr && paddr == ADDR_MCR |-> ##2 rts_n == !$past(pwdata[MCR_RTS], 2))
    else $error("rts pin wrong");
  irq_off_a: assert property (
    !gie_r && !$past(gie_r) |-> !irq_out)
    else $error("irq high while disabled");
  tbe_clr_a: assert property (
    wr && paddr == ADDR_TXBUF |-> ##[1:2] !tx_buffer_empty)
    else $error("buffer empty not cleared");
  dr_clr_a: assert property (
    psel && penable && !pwrite && paddr == ADDR_TXBUF
      |-> ##[1:2] !rx_data_ready)
    else $error("data ready not cleared");
  co_osc_a: assert property (
    !co_r && !$past(co_r, 4) && $rose(osc_in) |-> ##[1:3] clock_out_pin)
    else $error("clock out not following oscillator");
  mark_hold_a: assert property (
    cts_n && $past(cts_n, 4) && mark_cnt == 8'hFF |=> serial_tx_pin)
    else $error("start bit without clear to send");
  msr_cts_a: assert property (
    ($stable(cts_n))[*5] ##0 (psel && !penable && !pwrite
      && paddr == ADDR_MSR) |=> prdata[MSR_CTS] == !$past(cts_n))
    else $error("status image of cts wrong");
  irq_mdm_a: assert property (
    gie_r && mie_r && $changed(cts_n) |-> ##[3:6] irq_out)
    else $error("modem change gave no irq");
  rst_pins_a: assert property (
    disable iff (1'b0) !presetn |-> dtr_n && rts_n && serial_tx_pin
      && tx_buffer_empty && !rx_data_ready && !irq_out && !clock_out_pin)
    else $error("pins wrong in reset");
endmodule

bind usmr_top usmr_top_chk chk (.pclk, .presetn, .osc_in, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .cts_n, .dtr_n, .rts_n,
  .serial_tx_pin, .tx_buffer_empty, .rx_data_ready, .irq_out,
  .clock_out_pin);

// ==== usmr_line_model.sv ====
// Line partner model driving the serial receive line
`timescale 1ns/1ns
module usmr_line_model (
  // Clock
  input  wire logic pclk,
  // Serial line toward the block
  output logic      serial_rx_line
);
  // Idle mark, as a pulled-up line would rest
  initial serial_rx_line = 1'b1;
  // Start, eight data bits from bit 0, stop; slow or fast by bit_cyc
  task automatic send(input logic [7:0] v, input int bit_cyc);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx_line <= f[i];
      repeat (bit_cyc) @(posedge pclk);
    end
  endtask
endmodule

// ==== test_uart_modem_status_reset_pins.sv ====
// Self-checking bench for the modem, status and pin block
`timescale 1ns/1ns
module test_uart_modem_status_reset_pins;
  import usmr_pkg::*;
  localparam int BIT = 16;
  logic        pclk, presetn, osc_in, osc_run, psel, penable, pwrite;
  logic [7:0]  paddr, b, v;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, cts_n, dsr_n, dtr_n, rts_n;
  logic        serial_rx_line, serial_tx_pin, tx_buffer_empty;
  logic        rx_data_ready, irq_out, clock_out_pin;
  int          err_count, comparisons, n;

  usmr_top DUT (.pclk, .presetn, .ce(1'b1), .osc_in, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cts_n, .dsr_n,
    .dtr_n, .rts_n, .serial_rx_line, .serial_tx_pin, .tx_buffer_empty,
    .rx_data_ready, .irq_out, .clock_out_pin);
  usmr_line_model modem (.pclk, .serial_rx_line);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (osc_run) osc_in <= ~osc_in;

  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  // One APB transfer; an idle cycle follows so strobes never overlap
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int t;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
    if (t >= 50) err_count++;
    rd = prdata;
    chk("pslverr", 0, pslverr);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic do_reset(input int cyc);
    presetn <= 1'b0;
    repeat (cyc) @(posedge pclk);
    chk("reset pins", 32'h78, {dtr_n, rts_n, serial_tx_pin,
      tx_buffer_empty, rx_data_ready, irq_out, clock_out_pin});
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ADDR_LSR, 0); chk("lsr", LSR_RST_VAL, rd);
    apb(0, ADDR_MCR, 0); chk("mcr", MCR_RST_VAL, rd);
  endtask
  task automatic hold_mark(input int cyc, output int lows);
    lows = 0;
    repeat (cyc) begin
      @(posedge pclk);
      lows += (serial_tx_pin !== 1'b1);
    end
  endtask
  task automatic toggles(output int c);
    logic p;
    c = 0;
    // Let a select change reach the pin before counting
    repeat (2) @(posedge pclk);
    p = clock_out_pin;
    repeat (300) begin
      @(posedge pclk);
      c += (clock_out_pin !== p);
      p = clock_out_pin;
    end
  endtask
  // Catch one character; drop clear-to-send after bit 1 if asked
  task automatic grab(input logic drop, output logic [7:0] c);
    int t;
    t = 0;
    while (serial_tx_pin !== 1'b0 && t < 3000) begin
      @(posedge pclk); t++;
    end
    if (t >= 3000) err_count++;
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      c[i] = serial_tx_pin;
      if (drop && i == 1) cts_n <= 1'b1;
    end
    repeat (BIT) @(posedge pclk);
    chk("stop bit", 1, serial_tx_pin);
  endtask
  task automatic results();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    err_count++;
    results();
  end

  initial begin
    // Reset falls in do_reset, once every process waits for its edge
    presetn = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; cts_n = 1'b1; dsr_n = 1'b1;
    osc_in = 1'b0; osc_run = 1'b0; err_count = 0; comparisons = 0;
    n = $urandom(32'h6fd67386);
    do_reset(12);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom) & 8'h03;
      apb(1, ADDR_MCR, {24'h0, b});
      repeat (2) @(posedge pclk);
      chk("dtr pin", !b[0], dtr_n);
      chk("rts pin", !b[1], rts_n);
    end
    // Strobes without select must be ignored
    pwrite <= 1'b1; paddr <= ADDR_MCR; pwdata <= {30'h0, ~b[1:0]};
    @(posedge pclk) penable <= 1'b1;
    repeat (3) @(posedge pclk);
    penable <= 1'b0;
    chk("dtr unselected", !b[0], dtr_n);
    $display("modem pin test done");
    osc_in <= 1'b1;
    apb(1, ADDR_CTRL, 1);
    apb(1, ADDR_BAUD, 32'h81);
    toggles(n); chk("co baud clock", 1, n > 1);
    apb(1, ADDR_BAUD, 32'h01);
    toggles(n); chk("co still osc", 0, n);
    chk("co osc level", 1, clock_out_pin);
    osc_run <= 1'b1;
    $display("clock out test done");
    b = 8'($urandom);
    apb(1, ADDR_TXBUF, {24'h0, b});
    @(posedge pclk);
    chk("tbe after write", 0, tx_buffer_empty);
    hold_mark(400, n); chk("mark without cts", 0, n);
    cts_n <= 1'b0;
    grab(0, v); chk("tx byte", b, v);
    chk("tbe after move", 1, tx_buffer_empty);
    b = 8'($urandom);
    apb(1, ADDR_TXBUF, {24'h0, b});
    grab(1, v); chk("tx byte cts drop", b, v);
    $display("transmit test done");
    apb(1, ADDR_MCR, 32'h20);
    b = 8'($urandom);
    modem.send(b, BIT);
    n = 0;
    while (rx_data_ready !== 1'b1 && n < 100) begin
      @(posedge pclk); n++;
    end
    chk("data ready", 1, rx_data_ready);
    apb(0, ADDR_TXBUF, 0); chk("rx byte", b, rd);
    @(posedge pclk);
    chk("data ready cleared", 0, rx_data_ready);
    $display("receive test done");
    apb(1, ADDR_MCR, 32'h30);
    modem.send(~b, BIT);
    chk("rx ignored in loop", 0, rx_data_ready);
    b = 8'($urandom);
    apb(1, ADDR_TXBUF, {24'h0, b});
    hold_mark(400, n); chk("mark in loop", 0, n);
    apb(0, ADDR_TXBUF, 0); chk("loop byte", b, rd);
    $display("loop test done");
    apb(1, ADDR_MCR, 32'h0C);
    // Byte held back by clear-to-send keeps buffer-empty low
    apb(1, ADDR_TXBUF, 32'hA5);
    apb(0, ADDR_MSR, 0);
    @(posedge pclk);
    chk("irq quiet", 0, irq_out);
    dsr_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("irq on dsr change", 1, irq_out);
    cts_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("irq on change", 1, irq_out);
    apb(0, ADDR_MSR, 0); chk("msr change", 32'hF, rd);
    apb(0, ADDR_MSR, 0); chk("msr one event", 32'h3, rd);
    apb(1, ADDR_MCR, 32'h08);
    repeat (2) @(posedge pclk);
    chk("irq gated", 0, irq_out);
    apb(0, 8'h1C, 0); chk("unmapped read", 0, rd);
    $display("status test done");
    apb(1, ADDR_BAUD, 32'h81);
    osc_run <= 1'b0;
    do_reset(2);
    osc_in <= 1'b1;
    apb(1, ADDR_TXBUF, 32'h55);
    hold_mark(300, n); chk("idle after reset", 0, n);
    toggles(n); chk("co osc after reset", 0, n);
    $display("second reset test done");
    results();
  end
endmodule
